// [core/cscf_defs.vh]
// Constants for the card status-change flag block: register indices, field positions and reset values.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses equal to four times each index.
//
// Overview of operation
// - A flag whose event source is disabled always reads as 0.
// - An enabled source sets its flag when it becomes active and requests an interrupt.
// - Flags clear either on a read of the flag register or by writing 1.
// - Global control bit 2 selects read-to-clear or write-one-to-clear.
// - Flag register bits 7 to 4 always read as 0.
// - Bit 3 sets on a change of either card detect pin.
// - With a memory card, bit 2 sets on a rising ready pin.
// - With an I/O card, the ready flag is held at 0.
// - With a memory card, bit 1 sets on a battery-low warning.
// - With an I/O card, the battery-warning flag is held at 0.
// - Bit 0 reports battery dead or card status-change assertion.
// - Flag register at index 804h, read-only to ordinary writes, reset 00h.
// - Read/write route and mask register at index 805h, reset 00h.
// - Card-kind bit 0 means memory card, 1 means I/O card.
// - Mask bit 3 enables card detect change events.
// - Mask bit 1 enables battery-warning events, default off.
// - Mask bit 0 enables battery-dead or status-change events, default off.
`ifndef CSCF_DEFS_VH
`define CSCF_DEFS_VH

`define CSCF_IDX_W          12
`define CSCF_ADR_IDX_HI     13
`define CSCF_ADR_IDX_LO     2
`define CSCF_LANE0_HI       7
`define CSCF_IDX_GEN_CTRL   12'h803
`define CSCF_IDX_FLAGS      12'h804
`define CSCF_IDX_ROUTE_MASK 12'h805
`define CSCF_IDX_GLOBAL     12'h81E

`define CSCF_REG_RESET      8'h00
`define CSCF_READ_NONE      8'h00
`define CSCF_IRQ_RESET      1'b0
`define CSCF_RESERVED_BITS_ZERO      4'h0
`define CSCF_EVT_W          4
`define CSCF_ALL_EVENTS     4'hF
`define CSCF_NO_EVENTS      4'h0

`define CSCF_BIT_DETECT     3
`define CSCF_BIT_READY      2
`define CSCF_BIT_BAT_LOW    1
`define CSCF_BIT_BAT_DEAD   0

`define CSCF_BIT_CARD_KIND  5
`define CSCF_BIT_CLR_MODE   2

`define CSCF_FILL_INIT      2'h0
`define CSCF_RDATA_ZERO     32'h00000000
`define CSCF_PAD_ZERO       24'h000000

`endif

// [core/cscf_pin_edge.v]
// Two-flop synchroniser with edge detection for one card pin.
// Assumes the pin is asynchronous to mclk; edges are suppressed for the first two cycles after reset.
`timescale 1ns/1ps
`include "cscf_defs.vh"

module cscf_pin_edge (
  input  wire mclk,
  input  wire srst,
  input  wire pin,
  output wire level,
  output wire rise,
  output wire fall
);

  reg       meta;
  reg       sync;
  reg       prev;
  reg [1:0] fill;

  always @(posedge mclk) begin
    if (srst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      fill <= `CSCF_FILL_INIT;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
      fill <= {fill[0], 1'b1};
    end
  end

  // The fill bits mask edges for two cycles after reset; prev still holds 0 in the first unmasked cycle, so a pin already high still gives one rise.
  assign level = sync;
  assign rise  = fill[1] & sync & ~prev;
  assign fall  = fill[1] & ~sync & prev;

endmodule

// [core/cscf_flags.v]
// Card status-change flag block: event capture, flag clearing and host interrupt request.
// Assumes a classic Wishbone master on mclk and card pins asynchronous to mclk.
`timescale 1ns/1ps
`include "cscf_defs.vh"

module cscf_flags (
  input  wire        mclk,
  input  wire        srst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [13:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        card_detect1_n,
  input  wire        card_detect2_n,
  input  wire        card_ready,
  input  wire        card_battery_low,
  input  wire        card_battery_dead,
  output wire        card_kind_io,
  output wire        clear_by_write,
  output reg         csc_irq
);

  localparam ST_IDLE = 2'b01;
  localparam ST_ACK  = 2'b10;

  reg [1:0] state;
  reg [1:0] next_state;

  reg [7:0] gen_ctrl;
  reg [7:0] route_mask;
  reg [7:0] global_ctrl;
  reg [3:0] flags;

  reg [7:0]  next_gen_ctrl;
  reg [7:0]  next_route_mask;
  reg [7:0]  next_global_ctrl;
  reg [3:0]  next_flags;
  reg [31:0] next_rdata;
  reg [3:0]  clear_bits;
  reg [7:0]  read_byte;

  wire       det1_rise;
  wire       det1_fall;
  wire       det2_rise;
  wire       det2_fall;
  wire       ready_rise;
  wire       low_rise;
  wire       dead_rise;
  wire       detect_change;

  wire [`CSCF_IDX_W-1:0] word_idx;
  wire                   take;
  wire                   hit_gen;
  wire                   hit_flags;
  wire                   hit_mask;
  wire                   hit_global;
  wire                   lane0_write;
  wire                   read_clear;
  wire                   write_clear;

  wire [3:0] events;
  wire [3:0] kind_ok;
  wire [3:0] qualify;
  wire [3:0] visible;
  wire [7:0] flag_read;

  // Card pin synchronisers, one instance per pin.

  cscf_pin_edge u_det1 (
    .mclk  (mclk),
    .srst  (srst),
    .pin   (card_detect1_n),
    .level (),
    .rise  (det1_rise),
    .fall  (det1_fall)
  );

  cscf_pin_edge u_det2 (
    .mclk  (mclk),
    .srst  (srst),
    .pin   (card_detect2_n),
    .level (),
    .rise  (det2_rise),
    .fall  (det2_fall)
  );

  cscf_pin_edge u_ready (
    .mclk  (mclk),
    .srst  (srst),
    .pin   (card_ready),
    .level (),
    .rise  (ready_rise),
    .fall  ()
  );

  cscf_pin_edge u_low (
    .mclk  (mclk),
    .srst  (srst),
    .pin   (card_battery_low),
    .level (),
    .rise  (low_rise),
    .fall  ()
  );

  cscf_pin_edge u_dead (
    .mclk  (mclk),
    .srst  (srst),
    .pin   (card_battery_dead),
    .level (),
    .rise  (dead_rise),
    .fall  ()
  );

  // Card kind and clear mode come from software-written control bits.

  assign card_kind_io   = gen_ctrl[`CSCF_BIT_CARD_KIND];
  assign clear_by_write = global_ctrl[`CSCF_BIT_CLR_MODE];

  // Either detect pin moving in either direction counts as one detect change.

  assign detect_change = det1_rise | det1_fall | det2_rise | det2_fall;

  // Event sources, one per flag bit.

  assign events[`CSCF_BIT_DETECT]   = detect_change;
  assign events[`CSCF_BIT_READY]    = ready_rise;
  assign events[`CSCF_BIT_BAT_LOW]  = low_rise;
  assign events[`CSCF_BIT_BAT_DEAD] = dead_rise;

  // Ready and battery-warning flags only exist for a memory card.

  assign kind_ok[`CSCF_BIT_DETECT]   = 1'b1;
  assign kind_ok[`CSCF_BIT_READY]    = ~card_kind_io;
  assign kind_ok[`CSCF_BIT_BAT_LOW]  = ~card_kind_io;
  assign kind_ok[`CSCF_BIT_BAT_DEAD] = 1'b1;

  // Mask bits gate their sources; the ready enable sits in mask bit 2.

  assign qualify[`CSCF_BIT_DETECT]   = route_mask[`CSCF_BIT_DETECT] & kind_ok[`CSCF_BIT_DETECT];
  assign qualify[`CSCF_BIT_READY]    = route_mask[`CSCF_BIT_READY] & kind_ok[`CSCF_BIT_READY];
  assign qualify[`CSCF_BIT_BAT_LOW]  = route_mask[`CSCF_BIT_BAT_LOW] & kind_ok[`CSCF_BIT_BAT_LOW];
  assign qualify[`CSCF_BIT_BAT_DEAD] = route_mask[`CSCF_BIT_BAT_DEAD] & kind_ok[`CSCF_BIT_BAT_DEAD];

  assign visible   = flags & qualify;
  assign flag_read = {`CSCF_RESERVED_BITS_ZERO, visible};

  // Bus decode.

  assign word_idx    = wb_adr_i[`CSCF_ADR_IDX_HI:`CSCF_ADR_IDX_LO];
  assign take        = (state == ST_IDLE) & wb_cyc_i & wb_stb_i;
  assign hit_gen     = (word_idx == `CSCF_IDX_GEN_CTRL);
  assign hit_flags   = (word_idx == `CSCF_IDX_FLAGS);
  assign hit_mask    = (word_idx == `CSCF_IDX_ROUTE_MASK);
  assign hit_global  = (word_idx == `CSCF_IDX_GLOBAL);
  assign lane0_write = take & wb_we_i & wb_sel_i[0];
  assign read_clear  = take & hit_flags & ~wb_we_i & ~clear_by_write;
  assign write_clear = take & hit_flags & wb_we_i & wb_sel_i[0] & clear_by_write;
  assign wb_ack_o    = (state == ST_ACK);

  // The bus answers every access, mapped or not, one cycle after it is taken.

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (wb_cyc_i & wb_stb_i) begin
          next_state = ST_ACK;
        end
      end
      ST_ACK: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Register read mux; unmapped words read zero.

  always @* begin
    read_byte = `CSCF_READ_NONE;
    if (hit_flags) begin
      read_byte = flag_read;
    end else if (hit_mask) begin
      read_byte = route_mask;
    end else if (hit_gen) begin
      read_byte = gen_ctrl;
    end else if (hit_global) begin
      read_byte = global_ctrl;
    end
  end

  // Read data is captured when the access is taken, so it cannot change while the master waits for ack.

  always @* begin
    next_rdata = wb_dat_o;
    if (take & ~wb_we_i) begin
      next_rdata = {`CSCF_PAD_ZERO, read_byte};
    end
  end

  // Control registers take byte lane 0 only; the flag register ignores ordinary writes.
  // Each register has its own next-value process so a decode slip cannot touch a neighbour.

  always @* begin
    next_gen_ctrl = gen_ctrl;
    if (lane0_write & hit_gen) begin
      next_gen_ctrl = wb_dat_i[`CSCF_LANE0_HI:0];
    end
  end

  always @* begin
    next_route_mask = route_mask;
    if (lane0_write & hit_mask) begin
      next_route_mask = wb_dat_i[`CSCF_LANE0_HI:0];
    end
  end

  always @* begin
    next_global_ctrl = global_ctrl;
    if (lane0_write & hit_global) begin
      next_global_ctrl = wb_dat_i[`CSCF_LANE0_HI:0];
    end
  end

  // Flag clearing by read or by writing ones, chosen by the clear mode.

  always @* begin
    clear_bits = `CSCF_NO_EVENTS;
    if (read_clear) begin
      clear_bits = `CSCF_ALL_EVENTS;
    end else if (write_clear) begin
      clear_bits = wb_dat_i[`CSCF_EVT_W-1:0];
    end
  end

  // A new event wins over a clear in the same cycle, and a disabled source drops its flag.

  always @* begin
    next_flags = ((flags & ~clear_bits) | events) & qualify;
  end

  // Bus state; the ack cycle keeps a held request from being taken twice.

  always @(posedge mclk) begin
    if (srst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Software-visible control registers.

  always @(posedge mclk) begin
    if (srst) begin
      gen_ctrl    <= `CSCF_REG_RESET;
      route_mask  <= `CSCF_REG_RESET;
      global_ctrl <= `CSCF_REG_RESET;
    end else begin
      gen_ctrl    <= next_gen_ctrl;
      route_mask  <= next_route_mask;
      global_ctrl <= next_global_ctrl;
    end
  end

  // Flags hold until they are cleared or their source is disabled.

  always @(posedge mclk) begin
    if (srst) begin
      flags <= `CSCF_NO_EVENTS;
    end else begin
      flags <= next_flags;
    end
  end

  // The request follows the next flag value, so it rises and falls on the same edge as the flags.

  always @(posedge mclk) begin
    if (srst) begin
      csc_irq <= `CSCF_IRQ_RESET;
    end else begin
      csc_irq <= |next_flags;
    end
  end

  // Read data holds its last value between reads.

  always @(posedge mclk) begin
    if (srst) begin
      wb_dat_o <= `CSCF_RDATA_ZERO;
    end else begin
      wb_dat_o <= next_rdata;
    end
  end

endmodule

// [verification/cscf_flags_asserts.sv]
// Checker for cscf_flags: bus answer timing and register read values.
// Assumes it is bound to cscf_flags and sees only that module's ports.
`timescale 1ns/1ps
module cscf_flags_asserts (
  input wire        mclk,
  input wire        srst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [13:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        card_kind_io,
  input wire        csc_irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire req;
  assign req = wb_cyc_i && wb_stb_i;
  sequence s_take; req && !wb_ack_o; endsequence
  sequence s_rd; wb_ack_o && !wb_we_i; endsequence
  sequence s_rd_flags; s_rd ##0 wb_adr_i[13:2] == 12'h804; endsequence
  property p_ack; s_take |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse one cycle after request");
  property p_reserved_bits; s_rd_flags |-> wb_dat_o[31:4] == 28'h0000000; endproperty
  a_reserved_bits: assert property (p_reserved_bits) else $error("flag register upper bits not zero");
  property p_irq_flags; s_rd_flags |-> $past(csc_irq) == (wb_dat_o[3:0] != 4'h0); endproperty
  a_irq_flags: assert property (p_irq_flags) else $error("interrupt request disagrees with flags");
  property p_io; s_rd_flags ##0 $past(card_kind_io) |-> wb_dat_o[2:1] == 2'h0; endproperty
  a_io: assert property (p_io) else $error("ready or battery-low flag set with an I/O card");
  property p_unmapped; s_rd ##0 !(wb_adr_i[13:2] inside {12'h803, 12'h804, 12'h805, 12'h81E})
    |-> wb_dat_o == 32'h00000000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hi_zero; s_rd |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("read data above bit 7 not zero");
  property p_irq_hold; csc_irq && !req |=> csc_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt request dropped without an access");
  property p_dat_hold; !(req && !wb_we_i) |=> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data changed without a read");
endmodule
bind cscf_flags cscf_flags_asserts u_cscf_flags_asserts (.mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .card_kind_io, .csc_irq);

// [verification/cscf_card_model.sv]
// Card model: holds the socket pin levels and toggles those named by cmd.
// Assumes the bench pulses cmd for one cycle per change; detect pins low means a card is seated.
`timescale 1ns/1ps
module cscf_card_model (
  input  wire       mclk,
  input  wire [4:0] cmd,
  output wire       detect1_n,
  output wire       detect2_n,
  output wire       ready,
  output wire       battery_low,
  output wire       battery_dead
);
  reg [4:0] pins = 5'h00;
  assign {detect1_n, detect2_n, ready, battery_low, battery_dead} = pins;
  always @(posedge mclk) begin
    pins <= pins ^ cmd;
  end
endmodule

// [verification/tb_cscf_flags.sv]
// Testbench for cscf_flags: register access, card events and both clear modes.
// Assumes the card model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_cscf_flags;
  reg         mclk = 1'h0;
  reg         srst = 1'h1;
  reg         cyc = 1'h0;
  reg         we = 1'h0;
  reg  [13:0] adr = 14'h0000;
  reg  [31:0] wdat = 32'h00000000;
  reg  [4:0]  cmd = 5'h00;
  reg  [31:0] r;
  wire [31:0] rdat;
  wire        ack, cd1_n, cd2_n, rdy, blow, bdead, irq, kind_io, clr_w;
  integer     n_errors = 0;
  integer     comparisons = 0;
  always #12.5 mclk = ~mclk;
  cscf_flags u_cscf_flags (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .card_detect1_n(cd1_n),
    .card_detect2_n(cd2_n), .card_ready(rdy), .card_battery_low(blow), .card_battery_dead(bdead),
    .card_kind_io(kind_io), .clear_by_write(clr_w), .csc_irq(irq));
  cscf_card_model u_cscf_card_model (.mclk(mclk), .cmd(cmd), .detect1_n(cd1_n), .detect2_n(cd2_n),
    .ready(rdy), .battery_low(blow), .battery_dead(bdead));
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [11:0] idx, input [7:0] d);
    integer k;
    begin
      @(posedge mclk);
      cyc <= 1'h1;
      we <= w;
      adr <= {idx, 2'h0};
      wdat <= {24'h000000, d};
      k = 0;
      @(posedge mclk);
      while (ack !== 1'h1 && k < 8) begin
        @(posedge mclk);
        k = k + 1;
      end
      if (k == 8) begin
        n_errors = n_errors + 1;
        wrap_up;
      end
      r = rdat;
      cyc <= 1'h0;
    end
  endtask
  task rd(input [11:0] idx, input [7:0] exp);
    begin
      bus(1'h0, idx, 8'h00);
      chk(r, {24'h000000, exp});
    end
  endtask
  // Pulses one toggle request, then waits out the pin synchroniser and flag update.
  task pin(input [4:0] c);
    begin
      @(posedge mclk);
      cmd <= c;
      @(posedge mclk);
      cmd <= 5'h00;
      repeat (6) @(posedge mclk);
    end
  endtask
  task t_regs;
    begin
      rd(12'h804, 8'h00);
      rd(12'h805, 8'h00);
      rd(12'h900, 8'h00);
      chk({30'h0000000, kind_io, clr_w}, 32'h00000000);
      bus(1'h1, 12'h805, 8'hFF);
      rd(12'h805, 8'hFF);
      bus(1'h1, 12'h804, 8'hFF);
      rd(12'h804, 8'h00);
      bus(1'h1, 12'h805, 8'h00);
      pin(5'h10);
      rd(12'h804, 8'h00);
      chk({31'h00000000, irq}, 32'h00000000);
      $display("test regs_and_disabled done");
    end
  endtask
  task t_events;
    integer i;
    begin
      bus(1'h1, 12'h805, 8'h0F);
      for (i = 0; i < 4; i = i + 1) begin
        pin(5'h01 << i);
        chk({31'h00000000, irq}, 32'h00000001);
        rd(12'h804, 8'h01 << i);
        rd(12'h804, 8'h00);
        chk({31'h00000000, irq}, 32'h00000000);
        pin(5'h01 << i);
        bus(1'h0, 12'h804, 8'h00);
      end
      $display("test events_read_clear done");
    end
  endtask
  task t_w1c;
    begin
      bus(1'h1, 12'h81E, 8'h04);
      rd(12'h81E, 8'h04);
      chk({31'h00000000, clr_w}, 32'h00000001);
      pin(5'h10);
      rd(12'h804, 8'h08);
      rd(12'h804, 8'h08);
      bus(1'h1, 12'h804, 8'h07);
      rd(12'h804, 8'h08);
      bus(1'h1, 12'h804, 8'h08);
      rd(12'h804, 8'h00);
      chk({31'h00000000, irq}, 32'h00000000);
      bus(1'h1, 12'h803, 8'h20);
      rd(12'h803, 8'h20);
      chk({31'h00000000, kind_io}, 32'h00000001);
      pin(5'h06);
      rd(12'h804, 8'h00);
      bus(1'h1, 12'h803, 8'h00);
      pin(5'h06);
      pin(5'h06);
      rd(12'h804, 8'h06);
      chk({31'h00000000, irq}, 32'h00000001);
      bus(1'h1, 12'h805, 8'h09);
      rd(12'h804, 8'h00);
      chk({31'h00000000, irq}, 32'h00000000);
      $display("test write_clear_and_card_kind done");
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    srst <= 1'h0;
    t_regs;
    t_events;
    t_w1c;
    wrap_up;
  end
endmodule
